//--- hw/ucrc_pkg.sv
/*
  Constants, carriers and the CRC step shared by the packet check block.
  Assumes a single clock domain and byte-wide streams from the character layer.
*/
`default_nettype none

package ucrc_pkg;

  // ----------------------------------------
  // CRC engine
  // ----------------------------------------
  // Generator x^8+x^6+x^3+x^2+1 (0x4D), bit-reversed for LSB-first shifting
  localparam logic [7:0] CRC_REFLECTED_GENERATOR_CONSTANT_REFL  = 8'hB2;
  localparam logic [7:0] CRC_INIT       = 8'h00;
  localparam int         CRC_BITS       = 8;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_FIRST_STATUS_REGISTER   = 8'h04;
  localparam logic [7:0] ADDR_SECOND_STATUS_REGISTER   = 8'h08;
  localparam logic [7:0] ADDR_MASK1     = 8'h0C;
  localparam logic [7:0] ADDR_MASK2     = 8'h10;
  localparam logic [7:0] ADDR_LINK      = 8'h14;
  localparam logic [7:0] ADDR_REMAINDER = 8'h18;

  // Field positions
  localparam int CFG_DUAL_BIT    = 0;
  localparam int ST1_SUMMARY_BIT = 0;
  localparam int ST2_UP_BIT      = 0;
  localparam int ST2_DOWN_BIT    = 1;
  localparam int LINK_BAUD_BIT   = 8;
  localparam int LINK_MODE_BIT   = 9;

  // Reset values
  localparam logic       CONFIG_RST     = 1'b0;
  localparam logic       ST1_RST        = 1'b0;
  localparam logic [1:0] ST2_RST        = 2'h0;
  localparam logic [7:0] CHAIN_ADDR_RST = 8'h00;

  // Bus answers
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ----------------------------------------
  // Carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic       start;
    logic       is_alive;
    logic       is_check;
    logic       is_write;
    logic       path_down;
    logic [7:0] data;
  } ucrc_rx_byte_s;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } ucrc_tx_byte_s;

  typedef struct packed {
    logic       is_check;
    logic [7:0] data;
  } ucrc_tx_out_s;

  typedef enum logic [0:0] {
    TX_DATA  = 1'b0,
    TX_CHECK = 1'b1
  } ucrc_tx_state_e;

  // One byte through the engine, LSB first
  function automatic logic [7:0] crc_byte(input logic [7:0] crc_in, input logic [7:0] data);
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < CRC_BITS; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ CRC_REFLECTED_GENERATOR_CONSTANT_REFL;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

endpackage

`default_nettype wire

//--- hw/ucrc_checker.sv
/*
  Packet check for the daisy-chain UART: checks incoming packets, appends a
  check byte to outgoing read data, holds error flags behind AXI4-Lite.
  Assumes the character layer delivers whole bytes on aclk with their kind
  marked, and takes outgoing bytes through a valid/ready pair.
*/
// How it works
// R1 - Mismatch sets path error flag in status two and summary in status one.
// R2 - Single-port mode reports every check error as an up-path error.
// R3 - Dual-port mode reports errors on the path they arrived on.
// R4 - A write command executes only when its check byte matches.
// R5 - Host should read back written registers to confirm the write.
// R6 - Both ends use CRC-8 with generator x^8+x^6+x^3+x^2+1.
// R7 - Stream enters LSB first; remainder bit i is check bit i.
// R8 - Each incoming packet clears the engine, shifts bytes, compares next check byte.
// R9 - Match accepts and executes; mismatch rejects and raises error status.
// R10 - Outgoing data restarts the engine and is followed by its remainder.
// R11 - Host validates by direct compare or by zero final remainder.
// R12 - CRC covers bytes before the check byte; alive counter is skipped.
// R13 - Engine starts at zero for every command.
// R14 - Per byte: XOR in, then eight conditional right shifts with the constant.
// R15 - Read commands carry a data-check byte that the CRC also covers.
// R16 - After reset chain address is zero, baud and mode undetected.
// R17 - Error flags stay set until software clears them.
`timescale 1ns/1ps
`default_nettype none

module ucrc_checker (
  // Clock and reset
  input  wire  logic                   aclk,
  input  wire  logic                   aresetn,
  // AXI4-Lite slave
  input  wire  logic [7:0]             s_axi_awaddr,
  input  wire  logic                   s_axi_awvalid,
  output var   logic                   s_axi_awready,
  input  wire  logic [31:0]            s_axi_wdata,
  input  wire  logic [3:0]             s_axi_wstrb,
  input  wire  logic                   s_axi_wvalid,
  output var   logic                   s_axi_wready,
  output var   logic [1:0]             s_axi_bresp,
  output var   logic                   s_axi_bvalid,
  input  wire  logic                   s_axi_bready,
  input  wire  logic [7:0]             s_axi_araddr,
  input  wire  logic                   s_axi_arvalid,
  output var   logic                   s_axi_arready,
  output var   logic [31:0]            s_axi_rdata,
  output var   logic [1:0]             s_axi_rresp,
  output var   logic                   s_axi_rvalid,
  input  wire  logic                   s_axi_rready,
  // Incoming byte stream
  input  wire  logic                   rx_valid,
  input  wire  ucrc_pkg::ucrc_rx_byte_s rx_byte,
  // Packet verdicts
  output var   logic                   rx_accept,
  output var   logic                   rx_reject,
  output var   logic                   write_exec,
  // Outgoing byte stream in
  input  wire  logic                   tx_valid,
  input  wire  ucrc_pkg::ucrc_tx_byte_s tx_byte,
  output var   logic                   tx_ready,
  // Outgoing byte stream out
  output var   logic                   tx_out_valid,
  output var   ucrc_pkg::ucrc_tx_out_s tx_out,
  input  wire  logic                   tx_out_ready,
  // Link discovery events
  input  wire  logic                   addr_set,
  input  wire  logic [7:0]             addr_value,
  input  wire  logic                   baud_lock,
  input  wire  logic                   mode_lock,
  output var   logic [7:0]             chain_address,
  // Interrupt
  output var   logic                   irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic                     dual_mode_r;
  logic                     st1_r;
  logic [1:0]               st2_r;
  logic                     mask1_r;
  logic [1:0]               mask2_r;
  logic                     baud_det_r;
  logic                     mode_det_r;
  logic [7:0]               chain_addr_r;
  logic                     aw_held_r;
  logic [7:0]               aw_addr_r;
  logic                     w_held_r;
  logic [31:0]              w_data_r;
  logic [3:0]               w_strb_r;
  logic                     wr_do;
  logic                     wr_lane0;
  logic                     wr_mapped;
  logic                     in_pkt_r;
  logic [7:0]               rx_crc_r;
  logic                     chk_evt;
  logic                     chk_match;
  logic                     err_evt;
  logic                     err_down;
  ucrc_pkg::ucrc_tx_state_e tx_state_r;
  ucrc_pkg::ucrc_tx_state_e tx_state_nxt;
  logic                     tx_first_r;
  logic                     tx_first_nxt;
  logic [7:0]               tx_crc_r;
  logic [7:0]               tx_crc_nxt;
  logic                     tx_out_valid_nxt;
  ucrc_pkg::ucrc_tx_out_s   tx_out_nxt;
  logic                     tx_take;
  logic                     tx_out_taken;
  logic [31:0]              rd_word;
  logic                     rd_mapped;

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == ucrc_pkg::ADDR_CONFIG) || (a == ucrc_pkg::ADDR_FIRST_STATUS_REGISTER) ||
           (a == ucrc_pkg::ADDR_SECOND_STATUS_REGISTER) || (a == ucrc_pkg::ADDR_MASK1) ||
           (a == ucrc_pkg::ADDR_MASK2) || (a == ucrc_pkg::ADDR_LINK) ||
           (a == ucrc_pkg::ADDR_REMAINDER);
  endfunction
  // ----------------------------------------
  // Receive check
  // ----------------------------------------
  assign chk_evt   = rx_valid && rx_byte.is_check && !rx_byte.start && in_pkt_r;
  // R8 compare remainder with check byte
  assign chk_match = (rx_crc_r == rx_byte.data);
  assign err_evt   = chk_evt && !chk_match;
  // R2 single port: all errors up
  // R3 dual port: path of arrival
  assign err_down  = dual_mode_r && rx_byte.path_down;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_pkt_r <= 1'b0;
      rx_crc_r <= ucrc_pkg::CRC_INIT;
    end else if (rx_valid) begin
      if (rx_byte.start) begin
        // R13 engine restarts from zero
        // R8 clear then shift first byte
        in_pkt_r <= 1'b1;
        rx_crc_r <= ucrc_pkg::crc_byte(ucrc_pkg::CRC_INIT, rx_byte.data);
      end else if (rx_byte.is_check) begin
        // Engine stops at the check byte; stray check bytes are ignored
        in_pkt_r <= 1'b0;
      end else if (in_pkt_r && !rx_byte.is_alive) begin
        // R12 alive counter left out
        // R15 data-check byte is covered
        // R14 bytewise shift step
        // R6 common generator
        rx_crc_r <= ucrc_pkg::crc_byte(rx_crc_r, rx_byte.data);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_accept  <= 1'b0;
      rx_reject  <= 1'b0;
      write_exec <= 1'b0;
    end else begin
      // R9 accept on match, reject otherwise
      rx_accept  <= chk_evt && chk_match;
      rx_reject  <= err_evt;
      // R4 writes gated by a match
      write_exec <= chk_evt && chk_match && rx_byte.is_write;
    end
  end

  // ----------------------------------------
  // Transmit check byte
  // ----------------------------------------
  assign tx_take      = tx_valid && tx_ready;
  assign tx_out_taken = tx_out_valid && tx_out_ready;

  always_comb begin
    tx_state_nxt     = tx_state_r;
    tx_first_nxt     = tx_first_r;
    tx_crc_nxt       = tx_crc_r;
    tx_out_valid_nxt = tx_out_valid && !tx_out_taken;
    tx_out_nxt       = tx_out;
    unique case (tx_state_r)
      ucrc_pkg::TX_DATA: begin
        if (tx_take) begin
          // R10 clear on first outgoing byte
          // R7 LSB-first remainder
          tx_crc_nxt       = ucrc_pkg::crc_byte(tx_first_r ? ucrc_pkg::CRC_INIT : tx_crc_r, tx_byte.data);
          tx_first_nxt     = tx_byte.last;
          tx_out_nxt       = '{is_check: 1'b0, data: tx_byte.data};
          tx_out_valid_nxt = 1'b1;
          tx_state_nxt     = tx_byte.last ? ucrc_pkg::TX_CHECK : ucrc_pkg::TX_DATA;
        end
      end
      ucrc_pkg::TX_CHECK: begin
        if (!tx_out_valid || tx_out_taken) begin
          // R10 remainder follows as check byte
          tx_out_nxt       = '{is_check: 1'b1, data: tx_crc_r};
          tx_out_valid_nxt = 1'b1;
          tx_state_nxt     = ucrc_pkg::TX_DATA;
        end
      end
    endcase
  end

  // One slot only: a new byte is taken once the previous one has left
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_r   <= ucrc_pkg::TX_DATA;
      tx_first_r   <= 1'b1;
      tx_crc_r     <= ucrc_pkg::CRC_INIT;
      tx_out_valid <= 1'b0;
      tx_out       <= '0;
      tx_ready     <= 1'b0;
    end else begin
      tx_state_r   <= tx_state_nxt;
      tx_first_r   <= tx_first_nxt;
      tx_crc_r     <= tx_crc_nxt;
      tx_out_valid <= tx_out_valid_nxt;
      tx_out       <= tx_out_nxt;
      tx_ready     <= (tx_state_nxt == ucrc_pkg::TX_DATA) && !tx_out_valid_nxt;
    end
  end

  // ----------------------------------------
  // Bus write channel
  // ----------------------------------------
  assign wr_do     = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_lane0  = wr_do && w_strb_r[0];
  assign wr_mapped = addr_mapped(aw_addr_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_held_r      <= 1'b0;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ucrc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? ucrc_pkg::RESP_OKAY : ucrc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Control and status registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dual_mode_r <= ucrc_pkg::CONFIG_RST;
      mask1_r     <= 1'b0;
      mask2_r     <= 2'h0;
    end else if (wr_lane0) begin
      unique case (aw_addr_r)
        ucrc_pkg::ADDR_CONFIG: dual_mode_r <= w_data_r[ucrc_pkg::CFG_DUAL_BIT];
        ucrc_pkg::ADDR_MASK1:  mask1_r     <= w_data_r[ucrc_pkg::ST1_SUMMARY_BIT];
        ucrc_pkg::ADDR_MASK2:  mask2_r     <= w_data_r[1:0];
        default: ;
      endcase
    end
  end

  // Set beats clear so an error in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st1_r <= ucrc_pkg::ST1_RST;
      st2_r <= ucrc_pkg::ST2_RST;
    end else begin
      // R1 path and summary flags
      // R17 cleared only by software
      st1_r <= (st1_r & ~(wr_lane0 && aw_addr_r == ucrc_pkg::ADDR_FIRST_STATUS_REGISTER &&
                          w_data_r[ucrc_pkg::ST1_SUMMARY_BIT])) | err_evt;
      st2_r[ucrc_pkg::ST2_UP_BIT] <= (st2_r[ucrc_pkg::ST2_UP_BIT] &
          ~(wr_lane0 && aw_addr_r == ucrc_pkg::ADDR_SECOND_STATUS_REGISTER && w_data_r[ucrc_pkg::ST2_UP_BIT])) |
          (err_evt && !err_down);
      st2_r[ucrc_pkg::ST2_DOWN_BIT] <= (st2_r[ucrc_pkg::ST2_DOWN_BIT] &
          ~(wr_lane0 && aw_addr_r == ucrc_pkg::ADDR_SECOND_STATUS_REGISTER && w_data_r[ucrc_pkg::ST2_DOWN_BIT])) |
          (err_evt && err_down);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (st1_r && mask1_r) || (|(st2_r & mask2_r));
    end
  end

  // ----------------------------------------
  // Link discovery state
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // R16 address zero, nothing detected
      chain_addr_r <= ucrc_pkg::CHAIN_ADDR_RST;
      baud_det_r   <= 1'b0;
      mode_det_r   <= 1'b0;
    end else begin
      if (addr_set) begin
        chain_addr_r <= addr_value;
      end
      baud_det_r <= baud_det_r || baud_lock;
      mode_det_r <= mode_det_r || mode_lock;
    end
  end
  assign chain_address = chain_addr_r;

  // ----------------------------------------
  // Bus read channel
  // ----------------------------------------
  assign rd_mapped = addr_mapped(s_axi_araddr);

  always_comb begin
    rd_word = 32'h00000000;
    unique case (s_axi_araddr)
      ucrc_pkg::ADDR_CONFIG:    rd_word[ucrc_pkg::CFG_DUAL_BIT]    = dual_mode_r;
      ucrc_pkg::ADDR_FIRST_STATUS_REGISTER:   rd_word[ucrc_pkg::ST1_SUMMARY_BIT] = st1_r;
      ucrc_pkg::ADDR_SECOND_STATUS_REGISTER:   rd_word[1:0]                       = st2_r;
      ucrc_pkg::ADDR_MASK1:     rd_word[ucrc_pkg::ST1_SUMMARY_BIT] = mask1_r;
      ucrc_pkg::ADDR_MASK2:     rd_word[1:0]                       = mask2_r;
      ucrc_pkg::ADDR_LINK: begin
        rd_word[7:0]                    = chain_addr_r;
        rd_word[ucrc_pkg::LINK_BAUD_BIT] = baud_det_r;
        rd_word[ucrc_pkg::LINK_MODE_BIT] = mode_det_r;
      end
      ucrc_pkg::ADDR_REMAINDER: rd_word[7:0] = rx_crc_r;
      default: ;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= ucrc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_mapped ? ucrc_pkg::RESP_OKAY : ucrc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- bench/ucrc_monitor.sv
/*
  Port checks for the packet check block.
  Assumes it is bound to ucrc_checker: one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ucrc_monitor (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Bus answer
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [1:0]              s_axi_bresp,
  // Streams
  input wire logic                    rx_valid,
  input wire ucrc_pkg::ucrc_rx_byte_s rx_byte,
  input wire logic                    rx_accept,
  input wire logic                    rx_reject,
  input wire logic                    write_exec,
  input wire logic                    tx_valid,
  input wire ucrc_pkg::ucrc_tx_byte_s tx_byte,
  input wire logic                    tx_ready,
  input wire logic                    tx_out_valid,
  input wire ucrc_pkg::ucrc_tx_out_s  tx_out,
  input wire logic                    tx_out_ready,
  // Link state
  input wire logic                    addr_set,
  input wire logic [7:0]              addr_value,
  input wire logic [7:0]              chain_address
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_tx_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_last_take;
    s_tx_take ##0 tx_byte.last;
  endsequence

  chk_exec_match: assert property (write_exec |-> rx_accept && $past(rx_byte.is_write))
    else $error("write executed without a matching check byte");
  chk_verdict_once: assert property (!(rx_accept && rx_reject))
    else $error("accept and reject together");
  chk_verdict_cause: assert property ((rx_accept || rx_reject) |-> $past(rx_valid && rx_byte.is_check))
    else $error("verdict without a check byte");
  chk_tx_echo: assert property (s_tx_take |=> tx_out_valid && !tx_out.is_check && tx_out.data == $past(tx_byte.data))
    else $error("outgoing byte not passed on");
  chk_tx_hold: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out))
    else $error("outgoing byte changed while stalled");
  chk_check_follows: assert property (s_last_take |=> ##[1:300] (tx_out_valid && tx_out.is_check))
    else $error("no check byte after last data byte");
  chk_addr_load: assert property (addr_set |=> chain_address == $past(addr_value))
    else $error("chain address not loaded");
  chk_addr_reset: assert property ($rose(aresetn) |-> chain_address == 8'h00)
    else $error("chain address not zero after reset");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
endmodule
`default_nettype wire

//--- bench/ucrc_host_model.sv
/*
  Host side of the outgoing stream: stalls at random, checks each frame.
  Assumes frames end with one check byte marked in the carrier.
*/
`timescale 1ns/1ps
`default_nettype none
module ucrc_host_model (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Outgoing stream
  input  wire logic                   tx_out_valid,
  input  wire ucrc_pkg::ucrc_tx_out_s tx_out,
  output var  logic                   tx_out_ready
);
  int         seed = 32'h0A22E34A;
  int         frames;
  int         n_bad;
  logic [7:0] crc_r;
  logic [7:0] chk;
  logic [7:0] got[$];

  function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    repeat (8) x = x[0] ? ((x >> 1) ^ 8'hB2) : (x >> 1);
    return x;
  endfunction

  always @(posedge aclk) begin
    tx_out_ready <= 1'($random(seed));
    if (!aresetn) begin
      crc_r <= 8'h00;
      frames <= 0;
      n_bad <= 0;
    end else if (tx_out_valid && tx_out_ready) begin
      if (tx_out.is_check) begin
        frames <= frames + 1;
        chk <= tx_out.data;
        if (step(crc_r, tx_out.data) !== 8'h00) n_bad <= n_bad + 1;
        crc_r <= 8'h00;
      end else begin
        got.push_back(tx_out.data);
        crc_r <= step(crc_r, tx_out.data);
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/ucrc_checker_tb.sv
/*
  Self-checking bench: bus access, incoming packets, outgoing frames, link state.
  Assumes ucrc_host_model on the outgoing stream and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ucrc_checker_tb;
  logic                    aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                    rx_valid, tx_valid, addr_set, baud_lock, mode_lock;
  logic [7:0]              s_axi_awaddr, s_axi_araddr, addr_value;
  logic [31:0]             s_axi_wdata, rv;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              rr;
  ucrc_pkg::ucrc_rx_byte_s rx_byte;
  ucrc_pkg::ucrc_tx_byte_s tx_byte;
  wire logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic               rx_accept, rx_reject, write_exec, tx_ready, tx_out_valid, tx_out_ready, irq;
  wire logic [1:0]         s_axi_bresp, s_axi_rresp;
  wire logic [31:0]        s_axi_rdata;
  wire logic [7:0]         chain_address;
  wire ucrc_pkg::ucrc_tx_out_s tx_out;
  int                      fail_count, checked, seed, dual, st1, st2, last_crc;
  logic [7:0]              exp_q[$];

  ucrc_checker dut (.*);
  ucrc_host_model host (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("counts: %0d checked, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && t < 100);
    chk("write answer", s_axi_bvalid, 1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && t < 100);
    chk("read answer", s_axi_rvalid, 1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(what, rv, exp);
    chk(what, rr, 0);
  endtask

  // Alive byte after the first byte must not enter the remainder
  task automatic send_pkt(input int n, input logic wr, input logic dn, input logic bad);
    logic [7:0] c;
    logic [7:0] d;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      c = host.step(c, d);
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_byte <= {i == 0, 4'h0, d};
      if (i == 0) begin
        @(posedge aclk);
        rx_byte <= {5'b01000, d ^ 8'h5A};
      end
    end
    @(posedge aclk);
    rx_byte <= {3'b001, wr, dn, c ^ {7'h00, bad}};
    @(posedge aclk);
    rx_valid <= 1'b0;
    #1;
    chk("accept", rx_accept, !bad);
    chk("reject", rx_reject, bad);
    chk("write exec", write_exec, wr && !bad);
    last_crc = c;
    if (bad) begin
      st1 = 1;
      st2 = st2 | ((dual != 0 && dn) ? 2 : 1);
    end
  endtask

  task automatic send_tx(input int n);
    logic [7:0] c;
    logic [7:0] d;
    int t;
    int f0;
    c = 8'h00;
    f0 = host.frames;
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      c = host.step(c, d);
      exp_q.push_back(d);
      tx_valid <= 1'b1;
      tx_byte <= {i == n - 1, d};
      t = 0;
      do begin
        @(posedge aclk);
        t++;
      end while (!tx_ready && t < 100);
    end
    tx_valid <= 1'b0;
    for (t = 0; t < 300 && host.frames == f0; t++) @(posedge aclk);
    chk("frame count", host.frames, f0 + 1);
    chk("check byte", host.chk, c);
    chk("zero remainder", host.n_bad, 0);
    chk("got count", host.got.size(), exp_q.size());
    while (exp_q.size() > 0 && host.got.size() > 0) chk("tx data", host.got.pop_front(), exp_q.pop_front());
    exp_q.delete();
  endtask

  // ----------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    summarize();
  end

  initial begin
    seed = 32'h0A22E34A;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {rx_valid, tx_valid, addr_set, baud_lock, mode_lock} = '0;
    {s_axi_awaddr, s_axi_araddr, addr_value, s_axi_wdata, rx_byte, tx_byte} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd("config", 8'h00, 0);
    rd("first_status_register", 8'h04, 0);
    rd("second_status_register", 8'h08, 0);
    rd("link", 8'h14, 0);
    chk("chain address", chain_address, 0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) send_pkt(2 + k, k[0], k[1], 0);
    rd("first_status_register good", 8'h04, 0);
    rd("remainder", 8'h18, last_crc);
    chk("known step", host.step(8'h00, 8'h01), 8'h3E);
    $display("test good packets done");
    send_pkt(3, 1, 1, 1);
    rd("second_status_register single", 8'h08, st2);
    rd("first_status_register summary", 8'h04, st1);
    chk("irq masked", irq, 0);
    axw(8'h0C, 1);
    tick(2);
    chk("irq raised", irq, 1);
    send_pkt(2, 1, 0, 0);
    rd("first_status_register sticky", 8'h04, st1);
    axw(8'h04, 1);
    axw(8'h08, 3);
    st1 = 0;
    st2 = 0;
    tick(2);
    chk("irq cleared", irq, 0);
    rd("second_status_register cleared", 8'h08, 0);
    $display("test single port errors done");
    dual = 1;
    axw(8'h00, 1);
    rd("config", 8'h00, 1);
    s_axi_wstrb <= 4'hE;
    axw(8'h00, 0);
    s_axi_wstrb <= 4'hF;
    chk("strobe resp", rr, 0);
    rd("config strobe", 8'h00, 1);
    send_pkt(4, 1, 1, 1);
    rd("second_status_register down", 8'h08, st2);
    send_pkt(2, 0, 0, 1);
    rd("second_status_register both", 8'h08, st2);
    $display("test dual port errors done");
    axr(8'h40);
    chk("unmapped read resp", rr, 2);
    chk("unmapped read data", rv, 0);
    axw(8'h44, 1);
    chk("unmapped write resp", rr, 2);
    $display("test unmapped done");
    send_tx(3);
    send_tx(1);
    $display("test outgoing frames done");
    @(posedge aclk);
    {addr_set, baud_lock, mode_lock} <= 3'b111;
    addr_value <= 8'h2C;
    @(posedge aclk);
    {addr_set, baud_lock, mode_lock} <= 3'b000;
    rd("link set", 8'h14, 32'h0000032C);
    $display("test link done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd("link after reset", 8'h14, 0);
    rd("first_status_register after reset", 8'h04, 0);
    chk("chain address reset", chain_address, 0);
    $display("test second reset done");
    summarize();
  end
endmodule

bind ucrc_checker ucrc_monitor mon (.*);
`default_nettype wire
